// *** include/mscd_cfg.svh ***
// Constants of the memory-space configuration and program-address decode block.
// Notes on behaviour
// RULE_01 - After any reset, program and data spaces are limited to 64 KB each.
// RULE_02 - Setting bit 1 of the size control register widens program space to 1 MB.
// RULE_03 - Setting bit 0 of the size control register widens data space to 1 MB.
// RULE_04 - Unimplemented size control bits always read back as one.
// RULE_05 - Program bit is writable only after upper unlock nibble gets 5H then 0AH.
// RULE_06 - Data bit is writable only after lower unlock nibble gets 5H then 0AH.
// RULE_07 - Writing 55H then 0AAH unlocks both nibbles for one following write.
// RULE_08 - A set expansion bit takes effect after the following instruction has executed.
// RULE_09 - Size control accepts one write per reset; later writes are ignored.
// RULE_10 - Far jump, call or return without program expansion raises an opcode trap.
// RULE_11 - Sixteen 64 KB segments; code segment selects fetch segment, counter the offset.
// RULE_12 - Table reads and window accesses take the table segment instead.
// RULE_13 - Access pin high: up to 1FFFFH internal, 20000H to FFFFFH external.
// RULE_14 - Access pin low: every program address is fetched externally.
// RULE_15 - Software keeps internal code at or below 1FFFDH; table data to 1FFFFH.
// RULE_16 - External fetch: data port input, three address ports, program strobe active.
// RULE_17 - Software sets bus port secondary functions before using external program area.
// RULE_18 - Segment 0 slots 0000H-0049H and 006AH-0073H hold reset and interrupt vectors.
// RULE_19 - Reset or interrupt loads counter from 2-byte vector, low even, clears segment.
// RULE_20 - With program expansion, interrupt entry stacks code segment; return restores it.
// RULE_21 - Each external program access inserts zero to three wait states as configured.
// RULE_22 - An unlock nibble write out of order restarts that nibble's sequence.
`ifndef MSCD_CFG_SVH
`define MSCD_CFG_SVH
`define MSCD_OFS_CTRL 4'h0
`define MSCD_OFS_UNLOCK 4'h4
`define MSCD_OFS_WAIT 4'h8
`define MSCD_OFS_STATUS 4'hC
`define MSCD_BIT_DATA 0
`define MSCD_BIT_PROG 1
`define MSCD_CTRL_RST 1'b0
`define MSCD_CTRL_ONES 6'h3F
`define MSCD_KEY_FIRST 4'h5
`define MSCD_KEY_SECOND 4'hA
`define MSCD_WAIT_RST 2'h3
`define MSCD_INT_TOP 20'h1FFFF
`define MSCD_SEG_ZERO 4'h0
`define MSCD_VEC_END_A 7'h49
`define MSCD_VEC_BEG_B 7'h6A
`define MSCD_VEC_END_B 7'h73
`endif

// *** include/mscd_pkg.sv ***
// Types of the memory-space configuration and program-address decode block.
package mscd_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_ISSUE, ST_INT, ST_INTCAP, ST_EXT
  } mscd_fsm_t;
  typedef struct packed {
    mscd_fsm_t fsm;
    logic ack;
    logic [7:0] rdata;
    logic ctrl_prog;
    logic ctrl_data;
    logic eff_prog;
    logic eff_data;
    logic pend;
    logic written;
    logic five_hi;
    logic open_hi;
    logic five_lo;
    logic open_lo;
    logic [1:0] wait_cfg;
    logic [3:0] code_seg;
    logic [3:0] tbl_seg;
    logic trap;
    logic [1:0] waitcnt;
    logic [19:0] addr;
    logic vec;
    logic second;
    logic [7:0] vec_lo;
    logic [7:0] fdata;
    logic fvalid;
    logic [15:0] vpc;
    logic vdone;
    logic cs_push;
    logic [3:0] cs_push_val;
  } mscd_state_t;
endpackage

// *** design/mscd_top.sv ***
// Memory-space size control, unlock sequencing and program fetch address decode.
`timescale 1ns/10ps
`default_nettype none
`include "mscd_cfg.svh"
module mscd_top #(
  parameter int ADDR_W = 20
) (
  input wire logic sys_clk,
  input wire logic resetn,
  input wire logic [3:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic instr_retire,
  input wire logic far_jump_instr,
  input wire logic far_call_instr,
  input wire logic far_return_instr,
  input wire logic interrupt_return_instr,
  input wire logic [3:0] cs_restore,
  input wire logic csr_load,
  input wire logic [3:0] csr_value,
  input wire logic tsr_load,
  input wire logic [3:0] tsr_value,
  input wire logic vector_req,
  input wire logic vector_is_intr,
  input wire logic [6:0] vector_addr,
  input wire logic fetch_req,
  input wire logic fetch_is_table,
  input wire logic [15:0] fetch_offset,
  output logic fetch_busy,
  output logic [7:0] fetch_data,
  output logic fetch_valid,
  output logic [15:0] vector_pc,
  output logic vector_done,
  output logic cs_push,
  output logic [3:0] cs_push_val,
  output logic [3:0] code_segment_reg,
  output logic [3:0] table_segment_reg,
  output logic opcode_trap,
  output logic program_space_expand,
  output logic data_space_expand,
  output logic [16:0] int_mem_addr,
  output logic int_mem_rd,
  input wire logic [7:0] int_mem_data,
  input wire logic external_access_pin,
  input wire logic [7:0] port_data_in,
  output logic port_data_dir_in,
  output logic [7:0] port_addr_lo,
  output logic [7:0] port_addr_mid,
  output logic [3:0] port_addr_hi,
  output logic bus_port_en,
  output logic program_strobe_pin_n
);
  import mscd_pkg::*;

  mscd_state_t s;
  mscd_state_t n;
  logic req;
  logic wr_go;
  logic [7:0] rd_mux;
  logic [7:0] b;
  logic got;
  logic vec_ok;
  logic [3:0] seg;
  logic far_any;

  // The decode and the port split assume exactly a 20-bit program address.
  if (ADDR_W != 20) begin : g_addr_w_check
    $error("mscd_top serves a 20-bit program address only");
  end

  assign req = avs_read | avs_write;
  assign wr_go = avs_write & s.ack;
  assign far_any = far_jump_instr | far_call_instr | far_return_instr;

  // Only even slots inside the two vector regions are honoured.
  assign vec_ok = ~vector_addr[0] & ((vector_addr <= `MSCD_VEC_END_A) | // RULE_18
                  ((vector_addr >= `MSCD_VEC_BEG_B) & (vector_addr <= `MSCD_VEC_END_B)));

  always_comb begin
    case (avs_address)
      `MSCD_OFS_CTRL: rd_mux = {`MSCD_CTRL_ONES, s.ctrl_prog, s.ctrl_data}; // RULE_04
      `MSCD_OFS_WAIT: rd_mux = {6'h00, s.wait_cfg};
      `MSCD_OFS_STATUS: rd_mux = {external_access_pin, s.eff_prog, s.eff_data, s.pend,
                                  s.written, s.open_hi, s.open_lo, 1'b0};
      default: rd_mux = 8'h00;
    endcase
  end

  always_comb begin
    n = s;
    b = 8'h00;
    got = 1'b0;
    seg = `MSCD_SEG_ZERO;
    n.ack = req & ~s.ack;
    n.trap = 1'b0;
    n.fvalid = 1'b0;
    n.vdone = 1'b0;
    n.cs_push = 1'b0;
    if (req & ~s.ack & avs_read) begin
      n.rdata = rd_mux;
    end
    // The larger space waits for the next completed instruction.
    if (s.pend & instr_retire) begin
      n.eff_prog = s.ctrl_prog; // RULE_08
      n.eff_data = s.ctrl_data; // RULE_08
      n.pend = 1'b0;
    end
    if (wr_go & avs_byteenable[0]) begin
      case (avs_address)
        `MSCD_OFS_UNLOCK: begin
          if (avs_writedata[7:4] == `MSCD_KEY_FIRST) begin
            n.five_hi = 1'b1; // RULE_05
            n.open_hi = 1'b0;
          end else if ((avs_writedata[7:4] == `MSCD_KEY_SECOND) & s.five_hi) begin
            n.five_hi = 1'b0;
            n.open_hi = 1'b1; // RULE_05 RULE_07
          end else begin
            n.five_hi = 1'b0; // RULE_22
            n.open_hi = 1'b0;
          end
          if (avs_writedata[3:0] == `MSCD_KEY_FIRST) begin
            n.five_lo = 1'b1; // RULE_06
            n.open_lo = 1'b0;
          end else if ((avs_writedata[3:0] == `MSCD_KEY_SECOND) & s.five_lo) begin
            n.five_lo = 1'b0;
            n.open_lo = 1'b1; // RULE_06 RULE_07
          end else begin
            n.five_lo = 1'b0; // RULE_22
            n.open_lo = 1'b0;
          end
        end
        `MSCD_OFS_CTRL: begin
          if (!s.written) begin
            n.written = 1'b1; // RULE_09
            n.ctrl_prog = avs_writedata[`MSCD_BIT_PROG] & s.open_hi; // RULE_02 RULE_05
            n.ctrl_data = avs_writedata[`MSCD_BIT_DATA] & s.open_lo; // RULE_03 RULE_06
            n.pend = 1'b1;
          end
          n.five_hi = 1'b0;
          n.open_hi = 1'b0;
          n.five_lo = 1'b0;
          n.open_lo = 1'b0;
        end
        `MSCD_OFS_WAIT: begin
          n.wait_cfg = avs_writedata[1:0];
        end
        default: begin
        end
      endcase
    end
    n.trap = far_any & ~s.eff_prog; // RULE_10
    if (csr_load & s.eff_prog) begin
      n.code_seg = csr_value; // RULE_11
    end
    if (tsr_load) begin
      n.tbl_seg = tsr_value;
    end
    if (interrupt_return_instr & s.eff_prog) begin
      n.code_seg = cs_restore; // RULE_20
    end
    case (s.fsm)
      ST_IDLE: begin
        if (vector_req & vec_ok) begin
          n.addr = {13'h0000, vector_addr[6:1], 1'b0};
          n.vec = 1'b1;
          n.second = 1'b0;
          n.code_seg = `MSCD_SEG_ZERO; // RULE_19
          n.cs_push = vector_is_intr & s.eff_prog; // RULE_20
          n.cs_push_val = s.code_seg;
          n.fsm = ST_ISSUE;
        end else if (fetch_req) begin
          seg = fetch_is_table ? s.tbl_seg : s.code_seg; // RULE_12
          if (!s.eff_prog) begin
            seg = `MSCD_SEG_ZERO; // RULE_01
          end
          n.addr = {seg, fetch_offset}; // RULE_11
          n.vec = 1'b0;
          n.fsm = ST_ISSUE;
        end
      end
      ST_ISSUE: begin
        if (!external_access_pin | (s.addr > `MSCD_INT_TOP)) begin
          n.waitcnt = s.wait_cfg; // RULE_21
          n.fsm = ST_EXT; // RULE_13 RULE_14
        end else begin
          n.fsm = ST_INT; // RULE_13
        end
      end
      ST_INT: begin
        n.fsm = ST_INTCAP;
      end
      ST_INTCAP: begin
        b = int_mem_data;
        got = 1'b1;
      end
      ST_EXT: begin
        if (s.waitcnt == 2'h0) begin
          b = port_data_in; // RULE_16
          got = 1'b1;
        end else begin
          n.waitcnt = s.waitcnt - 2'h1; // RULE_21
        end
      end
      default: begin
        n.fsm = ST_IDLE;
      end
    endcase
    if (got) begin
      if (s.vec & !s.second) begin
        n.vec_lo = b; // RULE_19
        n.second = 1'b1;
        n.addr = s.addr + 20'h00001;
        n.fsm = ST_ISSUE;
      end else if (s.vec) begin
        n.vpc = {b, s.vec_lo}; // RULE_19
        n.vdone = 1'b1;
        n.vec = 1'b0;
        n.fsm = ST_IDLE;
      end else begin
        n.fdata = b;
        n.fvalid = 1'b1;
        n.fsm = ST_IDLE;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge resetn) begin
    if (!resetn) begin
      s <= '0;
      s.fsm <= ST_IDLE;
      s.ctrl_prog <= `MSCD_CTRL_RST;
      s.ctrl_data <= `MSCD_CTRL_RST;
      s.eff_prog <= `MSCD_CTRL_RST;
      s.eff_data <= `MSCD_CTRL_RST;
      s.wait_cfg <= `MSCD_WAIT_RST;
    end else begin
      s <= n;
    end
  end

  assign avs_waitrequest = req & ~s.ack;
  assign avs_readdata = {24'h000000, s.rdata};
  assign fetch_busy = (s.fsm != ST_IDLE);
  assign fetch_data = s.fdata;
  assign fetch_valid = s.fvalid;
  assign vector_pc = s.vpc;
  assign vector_done = s.vdone;
  assign cs_push = s.cs_push;
  assign cs_push_val = s.cs_push_val;
  assign code_segment_reg = s.code_seg;
  assign table_segment_reg = s.tbl_seg;
  assign opcode_trap = s.trap;
  assign program_space_expand = s.eff_prog;
  assign data_space_expand = s.eff_data;
  assign int_mem_rd = (s.fsm == ST_INT);
  assign int_mem_addr = s.addr[16:0];
  assign bus_port_en = (s.fsm == ST_EXT); // RULE_16
  assign port_data_dir_in = bus_port_en;
  assign program_strobe_pin_n = ~bus_port_en;
  assign port_addr_lo = bus_port_en ? s.addr[7:0] : 8'h00;
  assign port_addr_mid = bus_port_en ? s.addr[15:8] : 8'h00;
  assign port_addr_hi = bus_port_en ? s.addr[19:16] : 4'h0;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!resetn);

  property p_trap;
    far_any && !program_space_expand |=> opcode_trap;
  endproperty
  a_trap: assert property (p_trap) else $error("far instruction without trap"); // RULE_10

  property p_small_seg;
    (s.fsm == ST_ISSUE) && !s.vec && !s.eff_prog |-> s.addr[19:16] == 4'h0;
  endproperty
  a_small_seg: assert property (p_small_seg) else $error("segment used while small"); // RULE_01

  property p_once;
    wr_go && avs_address == `MSCD_OFS_CTRL && s.written |=> $stable({s.ctrl_prog, s.ctrl_data});
  endproperty
  a_once: assert property (p_once) else $error("second control write took effect"); // RULE_09

  property p_ones;
    avs_read && avs_waitrequest && avs_address == `MSCD_OFS_CTRL |=>
      avs_readdata[7:2] == 6'h3F;
  endproperty
  a_ones: assert property (p_ones) else $error("unused control bits not one"); // RULE_04

  property p_lock_hi;
    wr_go && avs_address == `MSCD_OFS_CTRL && avs_byteenable[0] && !s.written &&
      !s.open_hi |=> !s.ctrl_prog;
  endproperty
  a_lock_hi: assert property (p_lock_hi) else $error("program bit set while locked"); // RULE_05

  property p_lock_lo;
    wr_go && avs_address == `MSCD_OFS_CTRL && avs_byteenable[0] && !s.written &&
      !s.open_lo |=> !s.ctrl_data;
  endproperty
  a_lock_lo: assert property (p_lock_lo) else $error("data bit set while locked"); // RULE_06

  property p_delay;
    s.pend && !instr_retire |=> $stable({program_space_expand, data_space_expand});
  endproperty
  a_delay: assert property (p_delay) else $error("expansion before next instruction"); // RULE_08

  property p_ext_pin_low;
    (s.fsm == ST_ISSUE) && !external_access_pin |=> bus_port_en [*1] ##0 !program_strobe_pin_n;
  endproperty
  a_ext_pin_low: assert property (p_ext_pin_low) else $error("pin low, not external"); // RULE_14

  property p_int_map;
    (s.fsm == ST_ISSUE) && external_access_pin && s.addr <= 20'h1FFFF |=> int_mem_rd;
  endproperty
  a_int_map: assert property (p_int_map) else $error("internal address not internal"); // RULE_13

  property p_wait;
    $rose(bus_port_en) |-> bus_port_en [*1] ##1 (!bus_port_en || s.waitcnt < 2'h3);
  endproperty
  a_wait: assert property (p_wait) else $error("wait count not decreasing"); // RULE_21

  property p_vec_seg;
    vector_done |-> code_segment_reg == 4'h0 && $past(s.vec);
  endproperty
  a_vec_seg: assert property (p_vec_seg) else $error("vector left segment nonzero"); // RULE_19

  property p_restart_hi;
    wr_go && avs_address == `MSCD_OFS_UNLOCK && avs_byteenable[0] &&
      avs_writedata[7:4] != `MSCD_KEY_SECOND |=> !s.open_hi;
  endproperty
  a_restart_hi: assert property (p_restart_hi) else $error("upper unlock kept open"); // RULE_22

  property p_restart_lo;
    wr_go && avs_address == `MSCD_OFS_UNLOCK && avs_byteenable[0] &&
      avs_writedata[3:0] != `MSCD_KEY_SECOND |=> !s.open_lo;
  endproperty
  a_restart_lo: assert property (p_restart_lo) else $error("lower unlock kept open"); // RULE_22

  // One key pair written to both nibbles opens both halves together.
  property p_both;
    wr_go && avs_address == `MSCD_OFS_UNLOCK && avs_byteenable[0] && s.five_hi && s.five_lo &&
      avs_writedata[7:0] == {`MSCD_KEY_SECOND, `MSCD_KEY_SECOND} |=> s.open_hi && s.open_lo;
  endproperty
  a_both: assert property (p_both) else $error("both nibbles not opened"); // RULE_07

  property p_tbl_seg;
    s.fsm == ST_IDLE && !vector_req && fetch_req && fetch_is_table && s.eff_prog |=>
      s.addr[19:16] == $past(s.tbl_seg);
  endproperty
  a_tbl_seg: assert property (p_tbl_seg) else $error("table segment not used"); // RULE_12

  property p_ext_map;
    (s.fsm == ST_ISSUE) && external_access_pin && s.addr > 20'h1FFFF |=> bus_port_en;
  endproperty
  a_ext_map: assert property (p_ext_map) else $error("high address not external"); // RULE_13

  property p_ports;
    bus_port_en |-> port_data_dir_in && !program_strobe_pin_n &&
      {port_addr_hi, port_addr_mid, port_addr_lo} == s.addr;
  endproperty
  a_ports: assert property (p_ports) else $error("bus ports not in fetch role"); // RULE_16

  property p_push;
    s.fsm == ST_IDLE && vector_req && vec_ok && vector_is_intr && s.eff_prog |=>
      cs_push && cs_push_val == $past(s.code_seg);
  endproperty
  a_push: assert property (p_push) else $error("code segment not stacked"); // RULE_20

  property p_rti;
    interrupt_return_instr && s.eff_prog && !(s.fsm == ST_IDLE && vector_req && vec_ok) |=>
      code_segment_reg == $past(cs_restore);
  endproperty
  a_rti: assert property (p_rti) else $error("code segment not restored"); // RULE_20

  c_vector: cover property (vector_req && vec_ok ##[1:40] vector_done);
  c_ext_fetch: cover property (bus_port_en ##1 fetch_valid);
  c_expand: cover property ($rose(program_space_expand) && data_space_expand);
  c_ignored_ctrl: cover property (wr_go && avs_address == `MSCD_OFS_CTRL && s.written);
  c_trap: cover property (opcode_trap);
endmodule
`default_nettype wire

// *** test/mscd_ext_mem.sv ***
// External program memory model seen through the multiplexed bus ports.
`timescale 1ns/10ps
`default_nettype none
module mscd_ext_mem (
  input wire logic sys_clk,
  input wire logic strobe_n,
  input wire logic [19:0] addr,
  output logic [7:0] data
);
  logic [7:0] last_q = 8'h00;
  // Outside a strobe the released data port shows the inverse of the last byte.
  always_comb data = strobe_n ? ~last_q :
                     (addr[7:0] ^ addr[15:8] ^ {4'h0, addr[19:16]});
  always @(posedge sys_clk) begin
    if (!strobe_n) last_q <= data;
  end
endmodule
`default_nettype wire

// *** test/memory_space_config_decode_bench.sv ***
// Self-checking bench for the memory-space configuration and fetch decode block.
`timescale 1ns/10ps
`default_nettype none
`include "mscd_cfg.svh"
module memory_space_config_decode_bench;
  logic sys_clk, resetn, avs_read, avs_write, avs_waitrequest, instr_retire;
  logic [3:0] avs_address, avs_byteenable, cs_restore, csr_value, tsr_value, cs_push_val;
  logic [31:0] avs_writedata, avs_readdata;
  logic far_jump_instr, far_call_instr, far_return_instr, interrupt_return_instr;
  logic csr_load, tsr_load, vector_req, vector_is_intr, fetch_req, fetch_is_table;
  logic [6:0] vector_addr;
  logic [15:0] fetch_offset, vector_pc;
  logic fetch_busy, fetch_valid, vector_done, cs_push, opcode_trap;
  logic [7:0] fetch_data, port_data_in, port_addr_lo, port_addr_mid;
  logic [3:0] code_segment_reg, table_segment_reg, port_addr_hi;
  logic program_space_expand, data_space_expand, int_mem_rd, external_access_pin;
  logic [16:0] int_mem_addr;
  logic [7:0] int_mem_data = 8'h00;
  logic port_data_dir_in, bus_port_en, program_strobe_pin_n;
  int n_mismatch = 0;
  int compares = 0;

  mscd_top i_mscd_top (.*);
  // The bus ports stay wired to the memory for the whole run, as software would set them.
  mscd_ext_mem i_mscd_ext_mem (.sys_clk(sys_clk), .strobe_n(program_strobe_pin_n),
    .addr({port_addr_hi, port_addr_mid, port_addr_lo}), .data(port_data_in));

  function automatic logic [7:0] im(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ 8'h5A;
  endfunction
  function automatic logic [7:0] em(input logic [19:0] a);
    return a[7:0] ^ a[15:8] ^ {4'h0, a[19:16]};
  endfunction
  // Internal program memory answers one cycle after the address.
  always @(posedge sys_clk) int_mem_data <= im({3'h0, int_mem_addr});

  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic summarize;
    $display("Counts: %0d compares, %0d mismatches", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic do_reset;
    resetn <= 1'b0;
    repeat (8) @(posedge sys_clk);
    resetn <= 1'b1;
    @(posedge sys_clk);
  endtask

  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d,
                     output logic [7:0] q);
    bit done = 0;
    q = 8'h00;
    avs_address <= a;
    avs_writedata <= {24'h0, d};
    avs_read <= ~w;
    avs_write <= w;
    // Waitrequest and read data are both taken at the rising edge that ends the transfer.
    while (!done) begin
      @(posedge sys_clk);
      done = (avs_waitrequest === 1'b0);
      q = avs_readdata[7:0];
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge sys_clk);
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    logic [7:0] q;
    bus(1'b0, a, 8'h00, q);
    chk(q, e);
  endtask

  task automatic retire;
    instr_retire <= 1'b1;
    @(posedge sys_clk);
    instr_retire <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic seg(input logic t, input logic [3:0] v);
    csr_load <= ~t;
    tsr_load <= t;
    csr_value <= v;
    tsr_value <= v;
    @(posedge sys_clk);
    csr_load <= 1'b0;
    tsr_load <= 1'b0;
    @(posedge sys_clk);
  endtask

  task automatic fetch(input logic t, input logic [15:0] ofs, input logic [19:0] ea,
                       input logic ext, input int nw);
    bit done = 0;
    int st = 0;
    logic [19:0] seen = 20'h0;
    logic [7:0] d = 8'h00;
    fetch_req <= 1'b1;
    fetch_is_table <= t;
    fetch_offset <= ofs;
    @(posedge sys_clk);
    fetch_req <= 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      if ((program_strobe_pin_n === 1'b0) && (bus_port_en & port_data_dir_in) === 1'b1) begin
        st++;
        seen = {port_addr_hi, port_addr_mid, port_addr_lo};
      end
      if (int_mem_rd === 1'b1) seen = {3'h0, int_mem_addr};
      done = (fetch_valid === 1'b1);
      d = fetch_data;
      @(posedge sys_clk);
    end
    chk(seen, ea);
    chk(d, ext ? em(ea) : im(ea));
    chk(st, ext ? nw + 1 : 0);
  endtask

  task automatic t_far(input logic exp);
    for (int i = 0; i < 3; i++) begin
      far_jump_instr <= (i == 0);
      far_call_instr <= (i == 1);
      far_return_instr <= (i == 2);
      @(posedge sys_clk);
      far_jump_instr <= 1'b0;
      far_call_instr <= 1'b0;
      far_return_instr <= 1'b0;
      @(negedge sys_clk);
      chk(opcode_trap, exp);
      @(posedge sys_clk);
    end
    $display("t_far done");
  endtask

  task automatic t_vec(input logic push_exp, input logic [3:0] pv);
    bit done = 0;
    logic [4:0] pushed = 5'h0;
    vector_req <= 1'b1;
    vector_is_intr <= 1'b1;
    vector_addr <= 7'h08;
    @(posedge sys_clk);
    vector_req <= 1'b0;
    for (int n = 0; n < 40 && !done; n++) begin
      @(negedge sys_clk);
      if (cs_push === 1'b1) pushed = {1'b1, cs_push_val};
      done = (vector_done === 1'b1);
      @(posedge sys_clk);
    end
    chk(vector_pc, {im(20'h9), im(20'h8)});
    chk(code_segment_reg, 4'h0);
    chk(pushed, {push_exp, pv});
    $display("t_vec done");
  endtask

  task automatic t_bad_vec;
    vector_addr <= 7'h4A;
    vector_req <= 1'b1;
    @(posedge sys_clk);
    vector_req <= 1'b0;
    @(negedge sys_clk);
    chk(fetch_busy, 1'b0);
    @(posedge sys_clk);
    $display("t_bad_vec done");
  endtask

  task automatic t_small;
    rd(`MSCD_OFS_CTRL, 8'hFC);
    rd(`MSCD_OFS_WAIT, 8'h03);
    rd(4'h2, 8'h00);
    chk({program_space_expand, data_space_expand}, 2'b00);
    seg(1'b0, 4'h3);
    chk(code_segment_reg, 4'h0);
    seg(1'b1, 4'h3);
    chk(table_segment_reg, 4'h3);
    fetch(1'b1, 16'h1234, 20'h01234, 1'b0, 0);
    external_access_pin <= 1'b0;
    fetch(1'b0, 16'h0010, 20'h00010, 1'b1, 3);
    external_access_pin <= 1'b1;
    t_bad_vec();
    t_vec(1'b0, 4'h0);
    t_far(1'b1);
    $display("t_small done");
  endtask

  task automatic t_unlock;
    wr(`MSCD_OFS_UNLOCK, 8'h50);
    wr(`MSCD_OFS_UNLOCK, 8'h30);
    wr(`MSCD_OFS_UNLOCK, 8'hA0);
    wr(`MSCD_OFS_UNLOCK, 8'h05);
    wr(`MSCD_OFS_UNLOCK, 8'h0A);
    rd(`MSCD_OFS_STATUS, 8'h82);
    wr(`MSCD_OFS_CTRL, 8'h03);
    rd(`MSCD_OFS_CTRL, 8'hFD);
    chk(data_space_expand, 1'b0);
    retire();
    chk({program_space_expand, data_space_expand}, 2'b01);
    wr(`MSCD_OFS_UNLOCK, 8'h55);
    wr(`MSCD_OFS_UNLOCK, 8'hAA);
    wr(`MSCD_OFS_CTRL, 8'h03);
    rd(`MSCD_OFS_CTRL, 8'hFD);
    $display("t_unlock done");
  endtask

  task automatic t_large;
    do_reset();
    wr(`MSCD_OFS_UNLOCK, 8'h55);
    wr(`MSCD_OFS_UNLOCK, 8'hAA);
    wr(`MSCD_OFS_CTRL, 8'h03);
    rd(`MSCD_OFS_CTRL, 8'hFF);
    retire();
    chk({program_space_expand, data_space_expand}, 2'b11);
    seg(1'b0, 4'h2);
    for (int w = 0; w < 4; w++) begin
      wr(`MSCD_OFS_WAIT, w[7:0]);
      fetch(1'b0, 16'h00A5, 20'h200A5, 1'b1, w);
    end
    // Table data may use the very top of internal memory, code may not.
    seg(1'b1, 4'h1);
    fetch(1'b1, 16'hFFFF, 20'h1FFFF, 1'b0, 0);
    seg(1'b1, 4'h3);
    fetch(1'b1, 16'h0100, 20'h30100, 1'b1, 3);
    t_vec(1'b1, 4'h2);
    interrupt_return_instr <= 1'b1;
    cs_restore <= 4'h2;
    @(posedge sys_clk);
    interrupt_return_instr <= 1'b0;
    @(posedge sys_clk);
    chk(code_segment_reg, 4'h2);
    t_far(1'b0);
    $display("t_large done");
  endtask

  initial begin
    {resetn, avs_read, avs_write, instr_retire, far_jump_instr, far_call_instr} = '0;
    {far_return_instr, interrupt_return_instr, csr_load, tsr_load, vector_req} = '0;
    {vector_is_intr, fetch_req, fetch_is_table, cs_restore, csr_value, tsr_value} = '0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'hF;
    vector_addr = 7'h00;
    fetch_offset = 16'h0000;
    external_access_pin = 1'b1;
    do_reset();
    t_small();
    t_unlock();
    t_large();
    summarize();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_mismatch++;
    summarize();
  end
endmodule
`default_nettype wire
